// ==== hw/drs_cfg.svh ====
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DRS_OFF_COUNTS      8'h00
`define DRS_OFF_DEST_PTR    8'h04
`define DRS_OFF_ARRAY_IDX   8'h08
`define DRS_OFF_HOST_ACCESS_RANK   8'h0C
`define DRS_OFF_CNT_RELOAD  8'h10
`define DRS_OFF_SRC_BASE    8'h14
`define DRS_OFF_DEST_BASE   8'h18
`define DRS_OFF_SRC_PTR     8'h1C
`define DRS_OFF_STATUS      8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DRS_ACCESS_RANK_RANK_BIT   8
`define DRS_STAT_BUSY_BIT   0
`define DRS_STAT_SETS_LSB   8

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define DRS_RST_WORD        32'h0000_0000
`define DRS_RST_HALF        16'h0000
`define DRS_MAX_RD_BYTES    64
`define DRS_FIFO_DEPTH      8
`define DRS_DEST_SETS       4

`endif

// ==== hw/drs_pkg.sv ====
package drs_pkg;

   typedef enum logic {
      DRS_IDLE,
      DRS_ACTIVE
   } drs_state_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] len;
      logic        rank;
      logic [3:0]  tag;
   } drs_cmd_type;

endpackage

// ==== hw/drs_stream_if.sv ====
interface drs_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ==== hw/drs_fifo.sv ====
module drs_fifo
   import drs_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic   i_sys_clk,
   input  wire logic   i_srst,
   drs_stream_if.snk   in_if,
   drs_stream_if.src   out_if
);

   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_chk
      $error("drs_fifo depth must be a power of two of at least two.");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_if.ready  = (count_reg != DEPTH[AW:0]);
   assign out_if.valid = (count_reg != '0);
   assign out_if.data  = mem_reg[rd_ptr_reg];
   assign push         = in_if.valid && in_if.ready;
   assign pop          = out_if.valid && out_if.ready;

   always_ff @(posedge i_sys_clk)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= in_if.data;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule

// ==== hw/drs_read_state.sv ====
`include "drs_cfg.svh"

module drs_read_state
   import drs_pkg::*;
#(
   parameter int MAX_RD_BYTES = `DRS_MAX_RD_BYTES,
   parameter int FIFO_DEPTH   = `DRS_FIFO_DEPTH,
   parameter int DEST_SETS    = `DRS_DEST_SETS
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   input  wire logic        i_req_valid,
   output logic             o_req_ready,
   input  wire logic [31:0] i_req_src_addr,
   input  wire logic [15:0] i_req_byte_count,
   input  wire logic [15:0] i_req_array_quantity,
   input  wire logic [15:0] i_req_src_stride,
   input  wire logic        i_req_src_walk_style,
   input  wire logic [2:0]  i_req_fifo_width,
   input  wire logic        i_req_access_rank,
   input  wire logic [3:0]  i_req_host_rank_tag,
   output logic             o_rd_valid,
   input  wire logic        i_rd_ready,
   output logic [31:0]      o_rd_addr,
   output logic [15:0]      o_rd_len,
   output logic             o_rd_access_rank,
   output logic [3:0]       o_rd_host_rank_tag,
   output logic             o_wr_access_rank,
   output logic [3:0]       o_wr_host_rank_tag,
   output logic             o_job_done
);

   if (MAX_RD_BYTES < 1 || MAX_RD_BYTES > 65535 || DEST_SETS < 1 ||
       DEST_SETS > 255)
   begin : g_chk
      $error("drs_read_state parameters out of range.");
   end

   localparam logic [15:0] MAX_LEN  = 16'(MAX_RD_BYTES);
   localparam logic [7:0]  SETS_MAX = 8'(DEST_SETS - 1);

   // ----------------------------------------------------------------------
   // Job state
   // ----------------------------------------------------------------------
   drs_state_type state_reg;
   logic [15:0]   array_byte_count_reg;
   logic [15:0]   array_quantity_reg;
   logic [15:0]   reload_reg;
   logic [15:0]   stride_reg;
   logic [31:0]   base_reg;
   logic [31:0]   ptr_reg;
   logic          walk_reg;
   logic [2:0]    fwid_reg;
   logic          rank_reg;
   logic [3:0]    tag_reg;
   logic          done_reg;

   logic          load;
   logic          empty_job;
   logic          issue;
   logic [15:0]   len_w;
   logic          arr_end;
   logic          last;
   logic [31:0]   wrap_mask;
   logic [31:0]   ptr_inc;
   logic [31:0]   ptr_next;
   logic [31:0]   base_next;
   drs_cmd_type   cmd;

   drs_stream_if #(.WIDTH($bits(drs_cmd_type))) cmd_in ();
   drs_stream_if #(.WIDTH($bits(drs_cmd_type))) cmd_out ();

   assign o_req_ready = (state_reg == DRS_IDLE);
   assign load        = i_req_valid && o_req_ready;
   assign empty_job   = (i_req_byte_count == `DRS_RST_HALF ||
                         i_req_array_quantity == `DRS_RST_HALF);
   assign issue       = (state_reg == DRS_ACTIVE) && cmd_in.ready;

   assign len_w     = (array_byte_count_reg > MAX_LEN) ? MAX_LEN : array_byte_count_reg;
   assign arr_end   = (array_byte_count_reg == len_w);
   assign last      = arr_end && (array_quantity_reg <= 16'h0001 ||
                                  reload_reg == `DRS_RST_HALF);
   assign wrap_mask = (32'h0000_0001 << fwid_reg) - 32'h0000_0001;
   assign ptr_inc   = ptr_reg + {16'h0000, len_w};
   assign ptr_next  = walk_reg ? ((ptr_reg & ~wrap_mask) |
                                  (ptr_inc & wrap_mask))
                               : ptr_inc;
   assign base_next = base_reg + {16'h0000, stride_reg};

   assign cmd.addr  = ptr_reg;
   assign cmd.len   = len_w;
   assign cmd.rank  = rank_reg;
   assign cmd.tag   = tag_reg;

   assign cmd_in.data     = cmd;
   assign cmd_in.valid    = (state_reg == DRS_ACTIVE);
   assign cmd_out.ready   = i_rd_ready;

   drs_fifo #(
      .WIDTH ($bits(drs_cmd_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_cmd_fifo (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .in_if     (cmd_in),
      .out_if    (cmd_out)
   );

   assign o_rd_valid         = cmd_out.valid;
   assign {o_rd_addr, o_rd_len, o_rd_access_rank, o_rd_host_rank_tag}
                             = cmd_out.data;
   assign o_wr_access_rank   = rank_reg;
   assign o_wr_host_rank_tag = tag_reg;
   assign o_job_done         = done_reg;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state_reg <= DRS_IDLE;
      end
      else if (load)
      begin
         state_reg <= empty_job ? DRS_IDLE : DRS_ACTIVE;
      end
      else if (issue && last)
      begin
         state_reg <= DRS_IDLE;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         array_byte_count_reg <= `DRS_RST_HALF;
         array_quantity_reg <= `DRS_RST_HALF;
         ptr_reg  <= `DRS_RST_WORD;
         base_reg <= `DRS_RST_WORD;
      end
      else if (load)
      begin
         array_byte_count_reg <= empty_job ? `DRS_RST_HALF : i_req_byte_count;
         array_quantity_reg <= empty_job ? `DRS_RST_HALF : i_req_array_quantity;
         ptr_reg  <= i_req_src_addr;
         base_reg <= i_req_src_addr;
      end
      else if (issue)
      begin
         if (last)
         begin
            array_byte_count_reg <= `DRS_RST_HALF;
            array_quantity_reg <= `DRS_RST_HALF;
            ptr_reg  <= ptr_next;
         end
         else if (arr_end)
         begin
            array_byte_count_reg <= reload_reg;
            array_quantity_reg <= array_quantity_reg - 16'h0001;
            base_reg <= base_next;
            ptr_reg  <= base_next;
         end
         else
         begin
            array_byte_count_reg <= array_byte_count_reg - len_w;
            ptr_reg  <= ptr_next;
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         stride_reg <= `DRS_RST_HALF;
         walk_reg   <= 1'b0;
         fwid_reg   <= 3'h0;
         rank_reg   <= 1'b0;
         tag_reg    <= 4'h0;
      end
      else if (load)
      begin
         stride_reg <= i_req_src_stride;
         walk_reg   <= i_req_src_walk_style;
         fwid_reg   <= i_req_fifo_width;
         rank_reg   <= i_req_access_rank;
         tag_reg    <= i_req_host_rank_tag;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= issue && last;
      end
   end

   // ----------------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------------------------------------
   logic        ahb_acc;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [31:0] rd_val;

   assign ahb_acc     = i_hsel && i_htrans[1] && i_hready;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   // Reads are a pure mux of stored state, so they cannot disturb a job.
   always_comb
   begin
      rd_val = `DRS_RST_WORD;
      unique case (i_haddr[7:0])
         `DRS_OFF_COUNTS:     rd_val = {array_quantity_reg, array_byte_count_reg};
         `DRS_OFF_DEST_PTR:   rd_val = `DRS_RST_WORD;
         `DRS_OFF_ARRAY_IDX:  rd_val = {16'h0000, stride_reg};
         `DRS_OFF_HOST_ACCESS_RANK:
         begin
            rd_val                      = {28'h000_0000, tag_reg};
            rd_val[`DRS_ACCESS_RANK_RANK_BIT]  = rank_reg;
         end
         `DRS_OFF_CNT_RELOAD: rd_val = {16'h0000, reload_reg};
         `DRS_OFF_SRC_BASE:   rd_val = base_reg;
         `DRS_OFF_DEST_BASE:  rd_val = `DRS_RST_WORD;
         `DRS_OFF_SRC_PTR:    rd_val = ptr_reg;
         `DRS_OFF_STATUS:
         begin
            rd_val = {16'h0000, SETS_MAX, 8'h00};
            rd_val[`DRS_STAT_BUSY_BIT] = (state_reg == DRS_ACTIVE);
         end
         default:             rd_val = `DRS_RST_WORD;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         o_hrdata <= `DRS_RST_WORD;
      end
      else if (ahb_acc && !i_hwrite)
      begin
         o_hrdata <= rd_val;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end
      else
      begin
         wr_pend_reg <= ahb_acc && i_hwrite;
         wr_addr_reg <= i_haddr[7:0];
      end
   end

   // A job load takes precedence over a software write in the same cycle.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         reload_reg <= `DRS_RST_HALF;
      end
      else if (load)
      begin
         reload_reg <= i_req_byte_count;
      end
      else if (wr_pend_reg && wr_addr_reg == `DRS_OFF_CNT_RELOAD)
      begin
         reload_reg <= i_hwdata[15:0];
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   sequence s_array_step;
      issue && arr_end && !last;
   endsequence

   sequence s_mid_array;
      issue && !arr_end;
   endsequence

   sequence s_quiet_read;
      ahb_acc && !i_hwrite && !issue && !load;
   endsequence

   AST_DONE_ZERO: assert property (o_job_done |->
      (array_byte_count_reg == 16'h0000 && array_quantity_reg == 16'h0000 && o_req_ready))
      else $error("Counts not zero at job end.");

   AST_ARRAY_BYTE_COUNT_DEC: assert property (s_mid_array |=>
      array_byte_count_reg == $past(array_byte_count_reg) - $past(len_w))
      else $error("Byte count did not drop by the read length.");

   AST_ARRAY_QUANTITY_DEC: assert property (s_array_step |=>
      array_quantity_reg == $past(array_quantity_reg) - 16'h0001)
      else $error("Array count did not drop at array end.");

   AST_RELOAD: assert property (s_array_step |=>
      array_byte_count_reg == $past(reload_reg))
      else $error("Byte count not refilled from reload.");

   AST_BASE_STEP: assert property (s_array_step |=>
      base_reg == $past(base_reg) + {16'h0000, $past(stride_reg)}
      && ptr_reg == base_reg)
      else $error("Source base did not step by the stride.");

   AST_DEST_ZERO: assert property ((ahb_acc && !i_hwrite &&
      (i_haddr[7:0] == `DRS_OFF_DEST_PTR ||
       i_haddr[7:0] == `DRS_OFF_DEST_BASE)) |=> o_hrdata == 32'h0000_0000)
      else $error("Destination field read nonzero.");

   AST_CAPTURE: assert property (load |=>
      rank_reg == $past(i_req_access_rank) &&
      tag_reg == $past(i_req_host_rank_tag))
      else $error("Host attributes not captured at submit.");

   AST_CMD_ATTR: assert property (issue |->
      cmd_in.data[4:0] == {rank_reg, tag_reg} &&
      o_wr_access_rank == rank_reg && o_wr_host_rank_tag == tag_reg)
      else $error("Command carries wrong host attributes.");

   AST_WRAP: assert property ((s_mid_array and walk_reg) |=>
      (ptr_reg & ~wrap_mask) == ($past(ptr_reg) & ~wrap_mask))
      else $error("Wrapping pointer left its FIFO window.");

   AST_QUIET_READ: assert property (s_quiet_read |=>
      $stable(array_byte_count_reg) && $stable(array_quantity_reg) && $stable(ptr_reg)
      && $stable(state_reg))
      else $error("Register read disturbed the job.");

endmodule

// ==== sim/drs_rd_target.sv ====
// ----------------------------------------------------------------------
// Read endpoint that takes commands with an irregular ready pattern
// ----------------------------------------------------------------------
module drs_rd_target
(
   input  wire logic i_sys_clk,
   input  wire logic i_srst,
   input  wire logic i_hold,
   output logic      o_rd_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] lfsr_reg;

   // The pattern stalls about half the cycles, like a busy endpoint.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         lfsr_reg <= 16'hACE1;
      else
         lfsr_reg <= {lfsr_reg[14:0],
                      lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
   end

   always_ff @(posedge i_sys_clk)
   begin
      o_rd_ready <= !i_srst && !i_hold && lfsr_reg[0];
   end
endmodule

// ==== sim/tb_dma_read_side_state.sv ====
`include "drs_cfg.svh"

module tb_dma_read_side_state
   import drs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, srst, hsel, hwrite, hrdy, hresp, req_valid, req_ready;
   logic [31:0] haddr, hwdata, hrdata, req_src, rd_addr, seed, v;
   logic [1:0] htrans;
   logic [15:0] req_bc, req_q, req_st, rd_len;
   logic walk, rank, rd_valid, rd_ready, rd_rank, wr_rank, done, hold;
   logic [2:0] fw;
   logic [3:0] tag, rd_tag, wr_tag;
   drs_cmd_type exp_q[$];
   drs_cmd_type e;
   int failures, checked, done_cnt;

   drs_read_state dut_u (.i_sys_clk(clk), .i_srst(srst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
      .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
      .i_req_valid(req_valid), .o_req_ready(req_ready),
      .i_req_src_addr(req_src), .i_req_byte_count(req_bc),
      .i_req_array_quantity(req_q), .i_req_src_stride(req_st),
      .i_req_src_walk_style(walk), .i_req_fifo_width(fw),
      .i_req_access_rank(rank), .i_req_host_rank_tag(tag),
      .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_addr(rd_addr),
      .o_rd_len(rd_len), .o_rd_access_rank(rd_rank),
      .o_rd_host_rank_tag(rd_tag), .o_wr_access_rank(wr_rank),
      .o_wr_host_rank_tag(wr_tag), .o_job_done(done));

   drs_rd_target part_u (.i_sys_clk(clk), .i_srst(srst), .i_hold(hold),
      .o_rd_ready(rd_ready));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function void build_exp(logic [31:0] s, logic [15:0] bc, logic [15:0] q,
                           logic [15:0] st, logic w, logic [2:0] f,
                           logic r, logic [3:0] t);
      logic [31:0] b, a, m;
      int n;
      for (int i = 0; i < q; i++)
      begin
         b = s + 32'(i) * {16'h0000, st};
         for (int off = 0; off < bc; off += n)
         begin
            n = (bc - off > `DRS_MAX_RD_BYTES) ? `DRS_MAX_RD_BYTES : bc - off;
            a = b + 32'(off);
            m = (32'h0000_0001 << f) - 32'h0000_0001;
            if (w)
               a = (b & ~m) | ((b + 32'(off)) & m);
            exp_q.push_back({a, 16'(n), r, t});
         end
      end
   endfunction

   task print_verdict();
      if (failures == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task tmo(input logic bad);
      if (bad)
      begin
         failures++;
         print_verdict();
      end
   endtask

   task check_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task check_cmd(input drs_cmd_type got, input drs_cmd_type exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Commands are compared at the handshake edge with pre-edge values.
   always @(posedge clk)
   begin
      if (srst === 1'b0 && rd_valid === 1'b1 && rd_ready === 1'b1)
      begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
         check_cmd({rd_addr, rd_len, rd_rank, rd_tag}, e);
      end
      if (done === 1'b1)
         done_cnt++;
   end

   task wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hrdy !== 1'b1 && n < 50);
      if (hrdy !== 1'b1)
      begin
         failures++;
         print_verdict();
      end
   endtask

   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      v = hrdata;
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0000_0000);
      check_word(v, exp);
      check_word({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask

   task run_job(input logic [31:0] s, input logic [15:0] bc,
                input logic [15:0] q, input logic [15:0] st, input logic w,
                input logic [2:0] f, input logic r, input logic [3:0] t,
                input logic stall);
      int n, d0;
      build_exp(s, bc, q, st, w, f, r, t);
      d0 = done_cnt;
      @(posedge clk);
      hold <= stall;
      req_valid <= 1'b1;
      {req_src, req_bc, req_q, req_st, walk, fw, rank, tag} <=
         {s, bc, q, st, w, f, r, t};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (req_ready !== 1'b1 && n < 20000);
      tmo(req_ready !== 1'b1);
      req_valid <= 1'b0;
      if (stall)
      begin
         repeat (30) @(posedge clk);
         check_word({27'h0, wr_rank, wr_tag}, {27'h0, r, t});
         rchk(`DRS_OFF_HOST_ACCESS_RANK, {23'h0, r, 4'h0, t});
         rchk(`DRS_OFF_CNT_RELOAD, {16'h0000, bc});
         rchk(`DRS_OFF_ARRAY_IDX, {16'h0000, st});
         rchk(`DRS_OFF_DEST_PTR, 32'h0000_0000);
         rchk(`DRS_OFF_DEST_BASE, 32'h0000_0000);
         rchk(`DRS_OFF_SRC_BASE, s);
         ahb(1'b0, `DRS_OFF_COUNTS, 32'h0000_0000);
         check_word({16'h0000, v[31:16]}, {16'h0000, q});
         rchk(`DRS_OFF_STATUS, 32'h0000_0301);
         hold <= 1'b0;
      end
      n = 0;
      while (done_cnt == d0 && n < 20000 && bc != 0 && q != 0)
      begin
         @(negedge clk);
         n++;
      end
      tmo(done_cnt == d0 && bc != 0 && q != 0);
      n = 0;
      while (rd_valid === 1'b1 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      tmo(rd_valid === 1'b1);
      repeat (2) @(negedge clk);
      check_word(32'(done_cnt - d0), (bc != 0 && q != 0) ? 1 : 0);
      check_word(32'(exp_q.size()), 32'h0000_0000);
      rchk(`DRS_OFF_COUNTS, 32'h0000_0000);
   endtask

   initial
   begin
      seed = 32'h0000_2B8E;
      {srst, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {req_valid, req_src, req_bc, req_q, req_st, walk, fw} = '0;
      {rank, tag, hold, failures, checked, done_cnt} = '0;
      srst = 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i <= 9; i++)
         rchk(8'(i * 4), (i == 8) ? 32'h0000_0300 : 32'h0000_0000);
      rchk(8'h40, 32'h0000_0000);
      ahb(1'b1, `DRS_OFF_CNT_RELOAD, 32'hABCD_1234);
      rchk(`DRS_OFF_CNT_RELOAD, 32'h0000_1234);
      ahb(1'b1, `DRS_OFF_COUNTS, 32'hFFFF_FFFF);
      rchk(`DRS_OFF_COUNTS, 32'h0000_0000);
      run_job(32'h1000_0000, 16'h0400, 16'h0003, 16'h1000, 1'b0, 3'h0,
              1'b1, 4'hA, 1'b1);
      run_job(32'h2000_0040, 16'h0041, 16'h0002, 16'hFFFF, 1'b0, 3'h0,
              1'b0, 4'hF, 1'b0);
      run_job(32'h3000_0020, 16'h0060, 16'h0002, 16'h0040, 1'b1, 3'h5,
              1'b1, 4'h3, 1'b0);
      run_job(32'h4000_0000, 16'h0000, 16'h0002, 16'h0010, 1'b0, 3'h0,
              1'b0, 4'h1, 1'b0);
      for (int j = 0; j < 6; j++)
         run_job(rnd(), 16'(rnd() % 200 + 1), 16'(rnd() % 4 + 1),
                 16'(rnd()), 1'b0, 3'h0, 1'(rnd()),
                 4'(rnd()), 1'b0);
      print_verdict();
   end
endmodule
